// ---- logic/ubst_pkg.sv ----
/*
 Constants for the ultrasonic burst and saturation timer block.
 Assumes a 125 MHz mclk and word-indexed APB registers.
*/
package ubst_pkg;
   // Clock and step times in picoseconds
   localparam int CLK_PS   = 8000;
   localparam int TICK_PS  = 62500;
   localparam int DEG_PS   = 2000000;
   localparam int SAT_PS   = 16000000;
   localparam int TICK_CYC = (TICK_PS + CLK_PS - 1) / CLK_PS;
   localparam int DEG_CYC  = (DEG_PS + CLK_PS - 1) / CLK_PS;
   localparam int SAT_CYC  = (SAT_PS + CLK_PS - 1) / CLK_PS;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PCF  = 8'hAF;
   localparam logic [7:0] IDX_PCS  = 8'hB1;
   localparam logic [7:0] IDX_DEAD = 8'hB2;
   localparam logic [7:0] IDX_MODE = 8'hB3;
   localparam logic [7:0] IDX_TEMP = 8'hB4;
   localparam logic [7:0] IDX_SATF = 8'hB5;
   localparam logic [7:0] IDX_SATT = 8'hB6;
   localparam logic [7:0] IDX_ON1  = 8'hC0;
   localparam logic [7:0] IDX_OFF1 = 8'hC1;
   localparam logic [7:0] IDX_ON2  = 8'hC2;
   localparam logic [7:0] IDX_OFF2 = 8'hC3;
   localparam logic [7:0] IDX_CTRL = 8'hC4;
   localparam logic [7:0] IDX_STAT = 8'hC5;
   localparam logic [7:0] IDX_MASK = 8'hC6;

   // Control and status bit positions
   localparam int CTRL_START = 0;
   localparam int CTRL_SATEN = 1;
   localparam int CTRL_MAN1  = 2;
   localparam int CTRL_MAN2  = 3;
   localparam int ST_BURST   = 0;
   localparam int ST_SAT     = 1;

   localparam logic [7:0]  RST8  = 8'h00;
   localparam logic [10:0] RST11 = 11'h000;

   // Burst configuration codes
   localparam logic [2:0] MD_PP   = 3'h0;
   localparam logic [2:0] MD_SE1  = 3'h1;
   localparam logic [2:0] MD_SE2  = 3'h2;
   localparam logic [2:0] MD_SE12 = 3'h3;
   localparam logic [2:0] MD_MAN  = 3'h4;

   typedef enum logic [1:0] {PH_IDLE, PH_ON, PH_OFF} ubst_phase_e;
endpackage

// ---- logic/ubst_top.sv ----
/*
 Burst generator for two low-side drivers plus saturation timer,
 with an APB register slave and a masked level interrupt.
 Assumes envelope_below comes from an asynchronous comparator and
 temp_value from logic on mclk.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module ubst_top import ubst_pkg::*; (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  temp_value,
   input  wire logic        envelope_below,
   output logic             drive_out_first,
   output logic             drive_out_second,
   output logic             irq
);
   logic [1:0]  env_sync_ff;
   logic        env_below;
   logic [3:0]  tick_cnt_ff;
   logic        tick;
   logic [7:0]  pcf_ff;
   logic [7:0]  pcs_ff;
   logic [7:0]  dead_ff;
   logic [7:0]  mode_ff;
   logic [7:0]  satf_ff;
   logic [7:0]  temp_ff;
   logic [7:0]  sat_time_ff;
   logic [10:0] on_ff [2];
   logic [10:0] off_ff [2];
   logic        sat_en_ff;
   logic        sat_en_d_ff;
   logic [1:0]  man_ff;
   logic [1:0]  stat_ff;
   logic [1:0]  mask_ff;
   logic        start_ff;
   logic [31:0] prdata_ff;
   logic        err_ff;
   logic        wr;
   logic        addr_ok;
   logic [7:0]  idx;
   logic [31:0] rd_val;
   logic        hit;
   logic [1:0]  ch_start;
   logic [1:0]  high;
   logic [1:0]  busy;
   logic [1:0]  first_end;
   logic [5:0]  pulses [2];
   logic        was_busy_ff;
   logic        burst_done;
   logic        nxt_out1;
   logic        nxt_out2;
   logic        out1_ff;
   logic        out2_ff;
   logic        sat_run_ff;
   logic [10:0] sat_pre_ff;
   logic [7:0]  sat_tmr_ff;
   logic [7:0]  deg_pre_ff;
   logic [7:0]  deg_cnt_ff;
   logic        sat_fin;
   logic [1:0]  stat_set;
   logic [6:0]  rise1_ff;
   logic [6:0]  rise2_ff;

   // Comparator is asynchronous; two flops before any use
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         env_sync_ff <= 2'h0;
      end else begin
         env_sync_ff <= {env_sync_ff[0], envelope_below};
      end
   end
   assign env_below = env_sync_ff[1];

   // Oscillator tick, rounded up to whole mclk cycles
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_ff <= 4'h0;
      end else if (tick) begin
         tick_cnt_ff <= 4'h0;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 4'h1;
      end
   end
   assign tick = (tick_cnt_ff == 4'(TICK_CYC - 1));

   // APB decode
   assign idx     = paddr[9:2];
   assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
   assign wr      = psel && penable && pwrite && addr_ok;

   always_comb begin
      hit    = addr_ok;
      rd_val = 32'h0000_0000;
      unique case (idx)
         IDX_PCF:  rd_val[7:0] = pcf_ff;
         IDX_PCS:  rd_val[7:0] = pcs_ff;
         IDX_DEAD: rd_val[7:0] = dead_ff;
         IDX_MODE: rd_val[7:0] = mode_ff;
         IDX_TEMP: rd_val[7:0] = temp_ff;
         IDX_SATF: rd_val[7:0] = satf_ff;
         IDX_SATT: rd_val[7:0] = sat_time_ff;
         IDX_ON1:  rd_val[10:0] = on_ff[0];
         IDX_OFF1: rd_val[10:0] = off_ff[0];
         IDX_ON2:  rd_val[10:0] = on_ff[1];
         IDX_OFF2: rd_val[10:0] = off_ff[1];
         IDX_CTRL: rd_val[3:0] = {man_ff, sat_en_ff, 1'b0};
         IDX_STAT: rd_val[1:0] = stat_ff;
         IDX_MASK: rd_val[1:0] = mask_ff;
         default:  hit = 1'b0;
      endcase
   end

   // Answer is sampled in the setup cycle so no wait state is needed
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0000_0000;
         err_ff    <= 1'b0;
      end else if (psel && !penable) begin
         prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
         err_ff    <= !hit;
      end
   end
   assign prdata  = prdata_ff;
   assign pslverr = err_ff;
   assign pready  = 1'b1;

   // Software-written registers; temperature and capture are not here
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pcf_ff    <= RST8;
         pcs_ff    <= RST8;
         dead_ff   <= RST8;
         mode_ff   <= RST8;
         satf_ff   <= RST8;
         on_ff     <= '{RST11, RST11};
         off_ff    <= '{RST11, RST11};
         sat_en_ff <= 1'b0;
         man_ff    <= 2'h0;
         mask_ff   <= 2'h0;
      end else if (wr) begin
         unique case (idx)
            IDX_PCF:  pcf_ff    <= pwdata[7:0];
            IDX_PCS:  pcs_ff    <= pwdata[7:0];
            IDX_DEAD: dead_ff   <= pwdata[7:0];
            IDX_MODE: mode_ff   <= pwdata[7:0];
            IDX_SATF: satf_ff   <= pwdata[7:0];
            IDX_ON1:  on_ff[0]  <= pwdata[10:0];
            IDX_OFF1: off_ff[0] <= pwdata[10:0];
            IDX_ON2:  on_ff[1]  <= pwdata[10:0];
            IDX_OFF2: off_ff[1] <= pwdata[10:0];
            IDX_CTRL: begin
               sat_en_ff <= pwdata[CTRL_SATEN];
               man_ff    <= {pwdata[CTRL_MAN2], pwdata[CTRL_MAN1]};
            end
            IDX_MASK: mask_ff <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   // Temperature tracks the sensor; bus writes never reach it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         temp_ff <= RST8;
      end else begin
         temp_ff <= temp_value;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         start_ff <= 1'b0;
      end else begin
         start_ff <= wr && (idx == IDX_CTRL) && pwdata[CTRL_START];
      end
   end

   // Channel starts; push-pull delays the second until the first is off
   assign pulses[0] = pcf_ff[5:0];
   assign pulses[1] = pcs_ff[5:0];
   always_comb begin
      ch_start = 2'h0;
      unique case (mode_ff[2:0])
         MD_PP: begin
            ch_start[0] = start_ff;
            ch_start[1] = first_end[0]
                          || (start_ff && pulses[0] == 6'h00);
         end
         MD_SE1:  ch_start[0] = start_ff;
         MD_SE2:  ch_start[1] = start_ff;
         MD_SE12: ch_start    = {start_ff, start_ff};
         default: ch_start    = 2'h0;
      endcase
   end

   generate
      for (genvar c = 0; c < 2; c++) begin : g_ch
         logic [10:0] cnt_ff;
         logic [5:0]  left_ff;
         ubst_phase_e ph_ff;
         logic        on_end;
         logic        off_end;

         assign on_end  = ({1'b0, cnt_ff} + 12'h001) >= {1'b0, on_ff[c]};
         assign off_end = ({1'b0, cnt_ff} + 12'h001) >= {1'b0, off_ff[c]};

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               ph_ff   <= PH_IDLE;
               cnt_ff  <= RST11;
               left_ff <= 6'h00;
            end else if (ch_start[c]) begin
               cnt_ff  <= RST11;
               left_ff <= pulses[c];
               ph_ff   <= (pulses[c] == 6'h00) ? PH_IDLE : PH_ON;
            end else if (tick) begin
               unique case (ph_ff)
                  PH_IDLE: ;
                  PH_ON: begin
                     if (on_end) begin
                        ph_ff  <= PH_OFF;
                        cnt_ff <= RST11;
                     end else begin
                        cnt_ff <= cnt_ff + 11'h001;
                     end
                  end
                  PH_OFF: begin
                     if (off_end) begin
                        cnt_ff  <= RST11;
                        left_ff <= left_ff - 6'h01;
                        ph_ff   <= (left_ff == 6'h01) ? PH_IDLE : PH_ON;
                     end else begin
                        cnt_ff <= cnt_ff + 11'h001;
                     end
                  end
               endcase
            end
         end

         // High phase shortened by the dead interval at its end
         assign high[c] = (ph_ff == PH_ON)
                          && (({1'b0, cnt_ff} + {4'h0, dead_ff})
                              < {1'b0, on_ff[c]});
         assign busy[c] = (ph_ff != PH_IDLE);
         assign first_end[c] = tick && (ph_ff == PH_ON) && on_end
                               && (left_ff == pulses[c]);
      end
   endgenerate

   // Output selection; the first output wins any conflict
   always_comb begin
      unique case (mode_ff[2:0])
         MD_PP: begin
            nxt_out1 = high[0];
            nxt_out2 = high[1];
         end
         MD_SE1: begin
            nxt_out1 = high[0];
            nxt_out2 = man_ff[1];
         end
         MD_SE2: begin
            nxt_out1 = man_ff[0];
            nxt_out2 = high[1];
         end
         MD_SE12: begin
            nxt_out1 = high[0];
            nxt_out2 = high[1];
         end
         MD_MAN: begin
            nxt_out1 = man_ff[0];
            nxt_out2 = man_ff[1];
         end
         default: begin
            nxt_out1 = 1'b0;
            nxt_out2 = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out1_ff <= 1'b0;
         out2_ff <= 1'b0;
      end else begin
         out1_ff <= nxt_out1;
         out2_ff <= nxt_out2 && !nxt_out1;
      end
   end
   assign drive_out_first  = out1_ff;
   assign drive_out_second = out2_ff;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         was_busy_ff <= 1'b0;
      end else begin
         was_busy_ff <= |busy;
      end
   end
   assign burst_done = was_busy_ff && !(|busy);

   // Saturation timer and envelope deglitch
   assign sat_fin = sat_run_ff && env_below
                    && (deg_cnt_ff == satf_ff);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sat_en_d_ff <= 1'b0;
         sat_run_ff  <= 1'b0;
         sat_pre_ff  <= RST11;
         sat_tmr_ff  <= RST8;
         deg_pre_ff  <= RST8;
         deg_cnt_ff  <= RST8;
         sat_time_ff <= RST8;
      end else begin
         sat_en_d_ff <= sat_en_ff;
         if (sat_en_ff && !sat_en_d_ff) begin
            sat_run_ff <= 1'b1;
            sat_pre_ff <= RST11;
            sat_tmr_ff <= RST8;
            deg_pre_ff <= RST8;
            deg_cnt_ff <= RST8;
         end else if (!sat_en_ff || sat_fin) begin
            sat_run_ff <= 1'b0;
         end else if (sat_run_ff) begin
            // Timer holds at full scale rather than wrapping
            if (sat_pre_ff == 11'(SAT_CYC - 1)) begin
               sat_pre_ff <= RST11;
               if (sat_tmr_ff != 8'hFF) begin
                  sat_tmr_ff <= sat_tmr_ff + 8'h01;
               end
            end else begin
               sat_pre_ff <= sat_pre_ff + 11'h001;
            end
            // A rise above threshold restarts the deglitch window
            if (!env_below) begin
               deg_pre_ff <= RST8;
               deg_cnt_ff <= RST8;
            end else if (deg_pre_ff == 8'(DEG_CYC - 1)) begin
               deg_pre_ff <= RST8;
               deg_cnt_ff <= deg_cnt_ff + 8'h01;
            end else begin
               deg_pre_ff <= deg_pre_ff + 8'h01;
            end
         end
         if (sat_fin) begin
            sat_time_ff <= sat_tmr_ff;
         end
      end
   end

   // Sticky status, write one to clear; a new event beats the clear
   assign stat_set = {sat_fin, burst_done};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stat_ff <= 2'h0;
      end else if (wr && idx == IDX_STAT) begin
         stat_ff <= (stat_ff & ~pwdata[1:0]) | stat_set;
      end else begin
         stat_ff <= stat_ff | stat_set;
      end
   end
   assign irq = |(stat_ff & mask_ff);

   // Rising edges per burst, read only by the checks below
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rise1_ff <= 7'h00;
         rise2_ff <= 7'h00;
      end else if (start_ff) begin
         rise1_ff <= 7'h00;
         rise2_ff <= 7'h00;
      end else begin
         rise1_ff <= rise1_ff + 7'(nxt_out1 && !out1_ff);
         rise2_ff <= rise2_ff + 7'(nxt_out2 && !nxt_out1 && !out2_ff);
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   no_overlap_a: assert property (
      !(drive_out_first && drive_out_second))
      else $error("both driver outputs high");
   dead_cut_a: assert property (
      (drive_out_first && $past(mode_ff[2:0]) != MD_SE2
       && $past(mode_ff[2:0]) != MD_MAN)
      |-> (dead_ff < $past(on_ff[0])))
      else $error("first output high without on time left");
   tick_rate_a: assert property (
      tick |=> !tick [*7] ##1 tick)
      else $error("tick period wrong");
   count_second_a: assert property (
      (burst_done && mode_ff[2:0] == MD_SE2 && !man_ff[0]
       && dead_ff != 8'h00 && {3'h0, dead_ff} < on_ff[1])
      |-> rise2_ff == {1'b0, pcs_ff[5:0]})
      else $error("second output pulse count wrong");
   count_first_a: assert property (
      (burst_done && mode_ff[2:0] == MD_SE1
       && {3'h0, dead_ff} < on_ff[0])
      |-> rise1_ff == {1'b0, pcf_ff[5:0]})
      else $error("first output pulse count wrong");
   manual_mode_a: assert property (
      mode_ff[2:0] == MD_MAN |=> drive_out_first == $past(man_ff[0]))
      else $error("processor control not followed");
   illegal_mode_a: assert property (
      mode_ff[2:0] > MD_MAN |=> !drive_out_first && !drive_out_second)
      else $error("reserved mode drives outputs");
   deglitch_a: assert property (
      (!env_below && satf_ff != 8'h00 && !wr) |=> !sat_fin)
      else $error("deglitch done while envelope high");
   sat_done_a: assert property (
      sat_fin |=> stat_ff[ST_SAT] && !sat_run_ff)
      else $error("saturation done not flagged");
   sat_start_a: assert property (
      $rose(sat_en_ff) |=> sat_run_ff && sat_tmr_ff == 8'h00)
      else $error("saturation timer did not start");
   sat_capture_a: assert property (
      sat_fin |=> sat_time_ff == $past(sat_tmr_ff))
      else $error("saturation time not captured");
endmodule

// ---- bench/ubst_drv_model.sv ----
/*
 Model of the two low-side drivers and the envelope comparator.
 Assumes the bench pulses clr before each burst and drives below_req.
*/
`timescale 1ns/1ns
module ubst_drv_model (
   input  wire logic        mclk,
   input  wire logic        clr,
   input  wire logic        drive_out_first,
   input  wire logic        drive_out_second,
   input  wire logic        below_req,
   output logic             envelope_below,
   output logic      [31:0] n1,
   output logic      [31:0] n2,
   output logic      [31:0] hi1,
   output logic      [31:0] lo1,
   output logic             both_hi
);
   logic        p1;
   logic        p2;
   logic [31:0] run;
   // Comparator always drives its line, so no released state exists
   assign envelope_below = below_req;
   initial begin
      {p1, p2, both_hi} = 3'h0;
      {n1, n2, hi1, lo1, run} = '0;
   end
   always @(posedge mclk) begin
      if (clr) begin
         {n1, n2, hi1, lo1} = '0;
         both_hi = 1'b0;
         run = 32'h0;
      end else begin
         if (drive_out_first !== p1) begin
            if (p1) hi1 = run;
            else if (n1 != 0) lo1 = run;
            run = 32'h1;
         end else run = run + 32'h1;
         if (drive_out_first && !p1) n1 = n1 + 32'h1;
         if (drive_out_second && !p2) n2 = n2 + 32'h1;
         if (drive_out_first && drive_out_second) both_hi = 1'b1;
      end
      p1 = drive_out_first;
      p2 = drive_out_second;
   end
endmodule

// ---- bench/ultrasonic_burst_saturation_timer_bench.sv ----
/*
 Self-checking bench: register table, burst modes, saturation timer.
 Assumes the zero-wait APB slave and tick of eight mclk cycles.
*/
`timescale 1ns/1ns
module ultrasonic_burst_saturation_timer_bench import ubst_pkg::*;;
   typedef struct {
      logic [7:0] idx; logic [31:0] wd; logic [31:0] ex; logic er;
   } ubst_rrow_s;
   typedef struct {
      logic [2:0] md; logic [7:0] a; logic [7:0] b; logic [10:0] on;
      logic [10:0] off; logic [7:0] dt; logic [31:0] ea; logic [31:0] eb;
      logic [31:0] ehi; logic [31:0] elo;
   } ubst_brow_s;
   logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdq, n1, n2, hi1, lo1;
   logic [7:0]  temp_value;
   logic        envelope_below, below_req, clr, both_hi, rde;
   logic        drive_out_first, drive_out_second;
   int          num_errors, checks_done;
   ubst_rrow_s  rr [8];
   ubst_brow_s  br [5];
   logic [7:0]  ri [14];
   ubst_top uut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .temp_value(temp_value),
      .envelope_below(envelope_below), .drive_out_first(drive_out_first),
      .drive_out_second(drive_out_second), .irq(irq));
   ubst_drv_model prt (.mclk(mclk), .clr(clr),
      .drive_out_first(drive_out_first),
      .drive_out_second(drive_out_second), .below_req(below_req),
      .envelope_below(envelope_below), .n1(n1), .n2(n2), .hi1(hi1),
      .lo1(lo1), .both_hi(both_hi));
   initial mclk = 1'b0;
   always #4 mclk = ~mclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'h0, i, 2'h0};
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdq = prdata;
      rde = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      apb(1'b1, i, d);
   endtask
   task automatic burst(input ubst_brow_s r);
      int n;
      wr(IDX_MODE, {29'h0, r.md});
      wr(IDX_PCF, r.a);
      wr(IDX_PCS, r.b);
      wr(IDX_ON1, r.on);
      wr(IDX_OFF1, r.off);
      wr(IDX_ON2, r.on);
      wr(IDX_OFF2, r.off);
      wr(IDX_DEAD, r.dt);
      wr(IDX_MASK, 32'h1);
      @(posedge mclk) clr <= 1'b1;
      @(posedge mclk) clr <= 1'b0;
      wr(IDX_CTRL, 32'h1);
      n = 0;
      while (irq !== 1'b1 && n < 4000) begin
         @(posedge mclk);
         n++;
      end
      repeat (20) @(posedge mclk);
      chk(irq, 1'b1);
      chk(n1, r.ea);
      chk(n2, r.eb);
      chk(both_hi, 1'b0);
      if (r.ehi != 0) chk(hi1, r.ehi);
      if (r.elo != 0) chk(lo1, r.elo);
      wr(IDX_STAT, 32'h1);
      // Clear lands at the access edge; look one edge later
      @(posedge mclk);
      chk(irq, 1'b0);
   endtask
   initial begin
      #480000;
      num_errors++;
      test_done();
   end
   initial begin
      {rst_n, psel, penable, pwrite, below_req, clr} = 6'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      temp_value = 8'h00;
      num_errors = 0;
      checks_done = 0;
      ri = '{IDX_PCF, IDX_PCS, IDX_DEAD, IDX_MODE, IDX_TEMP, IDX_SATF,
             IDX_SATT, IDX_ON1, IDX_OFF1, IDX_ON2, IDX_OFF2, IDX_CTRL,
             IDX_STAT, IDX_MASK};
      rr = '{'{IDX_PCF, 32'h3F, 32'h3F, 1'b0},
             '{IDX_PCS, 32'h2A, 32'h2A, 1'b0},
             '{IDX_DEAD, 32'hFF, 32'hFF, 1'b0},
             '{IDX_MODE, 32'hF8, 32'hF8, 1'b0},
             '{IDX_SATF, 32'hA5, 32'hA5, 1'b0},
             '{IDX_TEMP, 32'hFF, 32'h5A, 1'b0},
             '{IDX_SATT, 32'hFF, 32'h00, 1'b0},
             '{8'hB0, 32'h11, 32'h00, 1'b1}};
      br = '{'{MD_PP, 3, 2, 4, 4, 1, 3, 2, 24, 40},
             '{MD_SE1, 2, 2, 3, 5, 0, 2, 0, 24, 40},
             '{MD_SE2, 2, 2, 4, 4, 1, 0, 2, 0, 0},
             '{MD_SE12, 0, 2, 4, 4, 1, 0, 2, 0, 0},
             '{MD_SE1, 63, 0, 1, 1, 0, 63, 0, 8, 8}};
      repeat (20) @(posedge mclk);
      chk({drive_out_first, drive_out_second, irq}, 3'h0);
      rst_n <= 1'b1;
      foreach (ri[k]) begin
         apb(1'b0, ri[k], 32'h0);
         chk(rdq, 32'h0);
      end
      temp_value <= 8'h5A;
      foreach (rr[k]) begin
         wr(rr[k].idx, rr[k].wd);
         chk(rde, rr[k].er);
         apb(1'b0, rr[k].idx, 32'h0);
         chk(rdq, rr[k].ex);
         chk(rde, rr[k].er);
      end
      foreach (br[k]) burst(br[k]);
      // Zero counts: nothing toggles and no completion is flagged
      wr(IDX_PCF, 32'h0);
      wr(IDX_PCS, 32'h0);
      wr(IDX_MODE, MD_PP);
      @(posedge mclk) clr <= 1'b1;
      @(posedge mclk) clr <= 1'b0;
      wr(IDX_CTRL, 32'h1);
      repeat (300) @(posedge mclk);
      chk({n1, n2}, 64'h0);
      chk(irq, 1'b0);
      // Processor mode: first output wins when both levels are asked
      wr(IDX_MODE, MD_MAN);
      wr(IDX_CTRL, 32'hC);
      repeat (4) @(posedge mclk);
      chk({drive_out_first, drive_out_second}, 2'h2);
      wr(IDX_CTRL, 32'h8);
      repeat (4) @(posedge mclk);
      chk({drive_out_first, drive_out_second}, 2'h1);
      wr(IDX_CTRL, 32'h0);
      // Saturation: short dip must not finish the filter
      wr(IDX_SATF, 32'h3);
      wr(IDX_MASK, 32'h2);
      wr(IDX_CTRL, 32'h2);
      repeat (3000) @(posedge mclk);
      below_req <= 1'b1;
      repeat (200) @(posedge mclk);
      below_req <= 1'b0;
      repeat (1300) @(posedge mclk);
      chk(irq, 1'b0);
      below_req <= 1'b1;
      repeat (1000) @(posedge mclk);
      chk(irq, 1'b1);
      apb(1'b0, IDX_STAT, 32'h0);
      chk(rdq, 32'h2);
      apb(1'b0, IDX_SATT, 32'h0);
      chk(rdq, 32'h2);
      wr(IDX_MASK, 32'h0);
      @(posedge mclk);
      chk(irq, 1'b0);
      wr(IDX_STAT, 32'h2);
      apb(1'b0, IDX_STAT, 32'h0);
      chk(rdq, 32'h0);
      below_req <= 1'b0;
      test_done();
   end
endmodule
